/* File: verilog/sscr_pkg.sv */
// Constants and types for the serial port control register block
`default_nettype none
package sscr_pkg;
   localparam logic [11:0] SSCR_CTRL_OFFS = 12'h014;
   localparam logic [11:0] SSCR_BUF_OFFS = 12'h018;
   localparam logic [11:0] SSCR_STAT_OFFS = 12'h01c;
   localparam logic [11:0] SSCR_CLR_OFFS = 12'h020;
   localparam logic [11:0] SSCR_IEN_OFFS = 12'h024;
   localparam logic [7:0] SSCR_CTRL_RESET = 8'h00;
   localparam int SSCR_WRITE_COLLISION_FLAG_BIT = 7;
   localparam int SSCR_OVF_BIT = 6;
   localparam int SSCR_EN_BIT = 5;
   localparam int SSCR_CKP_BIT = 4;
   localparam logic [3:0] SSCR_MODE_SLAVE_SS = 4'h4;
   localparam logic [3:0] SSCR_MODE_SLAVE_NOSS = 4'h5;
   localparam int SSCR_EVT_OVF = 0;
   localparam int SSCR_EVT_WRITE_COLLISION_FLAG = 1;
   localparam int SSCR_EVT_RX = 2;
   localparam int SSCR_NEVT = 3;

   typedef struct packed {
      logic write_collision_flag;
      logic receive_overflow_flag;
      logic port_enable_bit;
      logic clock_idle_polarity;
      logic [3:0] mode_select;
   } sscr_ctrl_t;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } sscr_apb_req_t;
endpackage
`default_nettype wire

/* File: verilog/sscr_ctrl.sv */
// Serial port control register with APB access and shift-engine flags
//
// Our own choice: the APB slave port.
`default_nettype none
module sscr_ctrl
   import sscr_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_in,
   // APB slave
   input wire sscr_apb_req_t apb_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // Shift engine status
   input wire logic rx_done_in,
   input wire logic [7:0] rx_byte_in,
   input wire logic tx_busy_in,
   // Shift engine control
   output logic tx_load_out,
   output logic [7:0] tx_byte_out,
   output logic port_enable_out,
   output logic spi_master_out,
   output logic spi_slave_out,
   output logic ss_ctrl_en_out,
   output logic clk_idle_level_out,
   output logic [3:0] mode_select_out,
   output logic pins_to_port_out,
   // Interrupt
   output logic irq_out
);
   sscr_ctrl_t ctrl_q;
   logic [7:0] buf_q;
   logic buf_full_q;
   logic [SSCR_NEVT-1:0] stat_q;
   logic [SSCR_NEVT-1:0] ien_q;
   logic [7:0] tx_q;
   logic tx_load_q;
   logic [31:0] rdata_q;
   logic wr_acc;
   logic rd_acc;
   logic buf_wr;
   logic buf_rd;
   logic is_spi;
   logic is_slave;
   logic ovf_evt;
   logic write_collision_flag_evt;
   logic [SSCR_NEVT-1:0] evt;
   logic addr_ok;

   // Every access completes in its first access cycle
   assign pready_out = 1'b1;
   assign wr_acc = apb_in.psel & apb_in.penable & apb_in.pwrite;
   assign rd_acc = apb_in.psel & apb_in.penable & ~apb_in.pwrite;
   assign buf_wr = wr_acc & (apb_in.paddr == SSCR_BUF_OFFS);
   assign buf_rd = rd_acc & (apb_in.paddr == SSCR_BUF_OFFS);
   assign addr_ok = (apb_in.paddr == SSCR_CTRL_OFFS) |
                    (apb_in.paddr == SSCR_BUF_OFFS) |
                    (apb_in.paddr == SSCR_STAT_OFFS) |
                    (apb_in.paddr == SSCR_CLR_OFFS) |
                    (apb_in.paddr == SSCR_IEN_OFFS);
   assign pslverr_out = apb_in.psel & apb_in.penable & ~addr_ok;

   // Mode decode
   assign is_spi = ~ctrl_q.mode_select[3] & ~ctrl_q.mode_select[2]
                   | (ctrl_q.mode_select == SSCR_MODE_SLAVE_SS)
                   | (ctrl_q.mode_select == SSCR_MODE_SLAVE_NOSS);
   assign is_slave = (ctrl_q.mode_select == SSCR_MODE_SLAVE_SS) |
                     (ctrl_q.mode_select == SSCR_MODE_SLAVE_NOSS);
   assign spi_master_out = ctrl_q.port_enable_bit &
                           (ctrl_q.mode_select[3:2] == 2'b00);
   assign spi_slave_out = ctrl_q.port_enable_bit & is_slave;
   assign ss_ctrl_en_out = ctrl_q.mode_select == SSCR_MODE_SLAVE_SS;
   assign mode_select_out = ctrl_q.mode_select;
   assign port_enable_out = ctrl_q.port_enable_bit;
   // Pins belong to the port only while enabled in SPI mode
   assign pins_to_port_out = ctrl_q.port_enable_bit &
                             is_spi;
   assign clk_idle_level_out = ctrl_q.clock_idle_polarity;

   // Overflow only counts when a slave receives into an unread buffer
   assign ovf_evt = rx_done_in & buf_full_q & ~buf_rd & is_slave &
                    ctrl_q.port_enable_bit;
   assign write_collision_flag_evt = buf_wr & tx_busy_in;
   assign evt[SSCR_EVT_OVF] = ovf_evt;
   assign evt[SSCR_EVT_WRITE_COLLISION_FLAG] = write_collision_flag_evt;
   assign evt[SSCR_EVT_RX] = rx_done_in & ~ovf_evt;

   // Control register; hardware set wins over a software write
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         ctrl_q <= SSCR_CTRL_RESET;
      end else begin
         if (wr_acc && apb_in.paddr == SSCR_CTRL_OFFS) begin
            ctrl_q <= apb_in.pwdata[7:0];
         end
         if (write_collision_flag_evt) begin
            ctrl_q.write_collision_flag <= 1'b1;
         end
         if (ovf_evt) begin
            ctrl_q.receive_overflow_flag <= 1'b1;
         end
      end
   end

   // Receive buffer; an overflowing byte is dropped
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         buf_q <= 8'h00;
         buf_full_q <= 1'b0;
      end else begin
         if (rx_done_in && !ovf_evt) begin
            buf_q <= rx_byte_in;
            buf_full_q <= 1'b1;
         end else if (buf_rd) begin
            buf_full_q <= 1'b0;
         end
      end
   end

   // Transmit load; a colliding write is ignored
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         tx_q <= 8'h00;
         tx_load_q <= 1'b0;
      end else begin
         tx_load_q <= buf_wr & ~tx_busy_in & ctrl_q.port_enable_bit;
         if (buf_wr && !tx_busy_in) begin
            tx_q <= apb_in.pwdata[7:0];
         end
      end
   end
   assign tx_load_out = tx_load_q;
   assign tx_byte_out = tx_q;

   // Sticky event status, write-one-to-clear, set wins
   genvar gi;
   generate
      for (gi = 0; gi < SSCR_NEVT; gi++) begin : g_evt
         always_ff @(posedge ref_clk_in) begin
            if (rst_in) begin
               stat_q[gi] <= 1'b0;
            end else if (evt[gi]) begin
               stat_q[gi] <= 1'b1;
            end else if (wr_acc && apb_in.paddr == SSCR_CLR_OFFS &&
                         apb_in.pwdata[gi]) begin
               stat_q[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         ien_q <= '0;
      end else if (wr_acc && apb_in.paddr == SSCR_IEN_OFFS) begin
         ien_q <= apb_in.pwdata[SSCR_NEVT-1:0];
      end
   end
   assign irq_out = |(stat_q & ien_q);

   // Read data
   always_comb begin
      rdata_q = 32'h0000_0000;
      unique case (apb_in.paddr)
         SSCR_CTRL_OFFS: rdata_q[7:0] = ctrl_q;
         SSCR_BUF_OFFS: rdata_q[7:0] = buf_q;
         SSCR_STAT_OFFS: rdata_q[SSCR_NEVT-1:0] = stat_q;
         SSCR_IEN_OFFS: rdata_q[SSCR_NEVT-1:0] = ien_q;
         default: rdata_q = 32'h0000_0000;
      endcase
   end
   assign prdata_out = rd_acc ? rdata_q : 32'h0000_0000;
endmodule
`default_nettype wire

/* File: test/sscr_monitor.sv */
// Port checker for the serial control register block
`default_nettype none
module sscr_mon
   import sscr_pkg::*;
(
   input wire logic ref_clk_in, rst_in,
   input wire sscr_apb_req_t apb_in,
   input wire logic [31:0] prdata_out,
   input wire logic pslverr_out, tx_busy_in, tx_load_out, port_enable_out,
   input wire logic spi_master_out, spi_slave_out, ss_ctrl_en_out,
   input wire logic clk_idle_level_out, pins_to_port_out,
   input wire logic [7:0] tx_byte_out,
   input wire logic [3:0] mode_select_out
);
   timeunit 1ns;
   timeprecision 1ps;
   wire logic acc = apb_in.psel & apb_in.penable;
   wire logic wr = acc & apb_in.pwrite;
   wire logic a_c = apb_in.paddr == SSCR_CTRL_OFFS;
   wire logic a_b = apb_in.paddr == SSCR_BUF_OFFS;
   wire logic a_ok = a_c | a_b | (apb_in.paddr inside
      {SSCR_STAT_OFFS, SSCR_CLR_OFFS, SSCR_IEN_OFFS});
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (rst_in);
   AST_ERR: assert property (acc |-> pslverr_out == !a_ok)
      else $error("slave error wrong");
   AST_RD0: assert property (acc & !a_ok |-> prdata_out == 0)
      else $error("unmapped read not zero");
   AST_CW: assert property (wr & a_c |=>
      {port_enable_out, clk_idle_level_out, mode_select_out}
      == $past(apb_in.pwdata[5:0])) else $error("control write lost");
   AST_MST: assert property (spi_master_out ==
      (port_enable_out & mode_select_out < 4)) else $error("master bad");
   AST_SLV: assert property (spi_slave_out ==
      (port_enable_out & (mode_select_out inside {4, 5})))
      else $error("slave bad");
   AST_SS: assert property (
      ss_ctrl_en_out == (mode_select_out == 4))
      else $error("select control bad");
   AST_PIN: assert property (pins_to_port_out ==
      (port_enable_out & mode_select_out < 6)) else $error("pins bad");
   AST_LD: assert property (
      wr & a_b & port_enable_out & !tx_busy_in |=>
      tx_load_out && tx_byte_out == $past(apb_in.pwdata[7:0]))
      else $error("load missed");
   AST_COL: assert property (wr & a_b & tx_busy_in |=>
      !tx_load_out && $stable(tx_byte_out)) else $error("collided load");
endmodule
`default_nettype wire

/* File: test/sscr_eng.sv */
// Shift engine model: receive pulses on request, busy after each load
`default_nettype none
module sscr_eng (
   input wire logic clk_in, rst_in, rx_req_in, tx_load_in,
   input wire logic [7:0] rx_val_in,
   input wire logic [3:0] busy_len_in,
   output logic rx_done_out, tx_busy_out,
   output logic [7:0] rx_byte_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] cnt_q;
   always_ff @(posedge clk_in) begin
      rx_done_out <= rx_req_in & !rst_in;
      // Byte lines only mean something with the done pulse
      rx_byte_out <= rx_req_in ? rx_val_in : ~rx_byte_out;
      if (rst_in) cnt_q <= 4'h0;
      else if (tx_load_in) cnt_q <= busy_len_in;
      else if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
   end
   assign tx_busy_out = cnt_q != 4'h0;
endmodule
`default_nettype wire

/* File: test/testbench.sv */
// Self-checking bench for the serial control register block
`default_nettype none
module testbench
   import sscr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk_in = 0, rst_in = 1, rx_req = 0, pready, irq, rx_d, busy, ld;
   logic [7:0] rx_val = 8'h00, rx_b;
   logic [31:0] prdata, q[$];
   sscr_apb_req_t apb = '0;
   int num_errors = 0, n_compared = 0, cyc = 0, seed = 71;
   always #2 ref_clk_in = ~ref_clk_in;
   sscr_ctrl dut(.ref_clk_in, .rst_in, .apb_in(apb), .prdata_out(prdata),
      .pready_out(pready), .pslverr_out(), .rx_done_in(rx_d),
      .rx_byte_in(rx_b), .tx_busy_in(busy), .tx_load_out(ld),
      .tx_byte_out(), .port_enable_out(), .spi_master_out(),
      .spi_slave_out(), .ss_ctrl_en_out(), .clk_idle_level_out(),
      .mode_select_out(), .pins_to_port_out(), .irq_out(irq));
   sscr_eng eng(.clk_in(ref_clk_in), .rst_in, .rx_req_in(rx_req),
      .tx_load_in(ld), .rx_val_in(rx_val), .busy_len_in(4'h8),
      .rx_done_out(rx_d), .tx_busy_out(busy), .rx_byte_out(rx_b));
   task automatic chk(logic [31:0] s, e);
      n_compared++;
      if (s !== e) begin
         num_errors++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic bus(logic w, logic [11:0] a, logic [31:0] d);
      @(posedge ref_clk_in);
      apb <= '{1'b1, 1'b0, w, a, d};
      @(posedge ref_clk_in);
      apb.penable <= 1'b1;
      do @(posedge ref_clk_in); while (pready !== 1'b1);
      apb.psel <= 1'b0;
      apb.penable <= 1'b0;
   endtask
   task automatic rd(logic [11:0] a, logic [31:0] e);
      q.push_back(e);
      bus(1'b0, a, 32'h0);
   endtask
   task automatic rx(logic [7:0] v);
      @(posedge ref_clk_in);
      rx_req <= 1'b1;
      rx_val <= v;
      // One edge of request gives exactly one done pulse
      @(posedge ref_clk_in);
      rx_req <= 1'b0;
   endtask
   task automatic irq_is(logic [11:0] a, logic [31:0] d, logic e);
      bus(1'b1, a, d);
      repeat (2) @(posedge ref_clk_in);
      chk(irq, e);
   endtask
   task automatic print_verdict;
      $display("compared %0d mismatched %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   always @(posedge ref_clk_in) begin
      cyc++;
      if (apb.psel && apb.penable && !apb.pwrite && pready === 1'b1)
         chk(prdata, q.pop_front());
      if (cyc == 3000) begin
         num_errors++;
         print_verdict();
      end
   end
   initial begin
      logic [7:0] v;
      repeat (20) @(posedge ref_clk_in);
      rst_in <= 1'b0;
      rd(SSCR_CTRL_OFFS, 32'h0);
      rd(12'h0fc, 32'h0);
      for (int m = 0; m < 16; m++) begin
         v = {2'b00, 2'($random(seed)), 4'(m)};
         bus(1'b1, SSCR_CTRL_OFFS, {24'h0, v});
         rd(SSCR_CTRL_OFFS, {24'h0, v});
      end
      $display("modes done");
      bus(1'b1, SSCR_CTRL_OFFS, 32'h24);
      rx(8'($random(seed)));
      v = rx_val;
      rx(8'h5a);
      rd(SSCR_CTRL_OFFS, 32'h64);
      rd(SSCR_BUF_OFFS, {24'h0, v});
      rd(SSCR_STAT_OFFS, 32'h5);
      irq_is(SSCR_IEN_OFFS, 32'h2, 1'b0);
      irq_is(SSCR_IEN_OFFS, 32'h3, 1'b1);
      irq_is(SSCR_CLR_OFFS, 32'h7, 1'b0);
      $display("slave overflow done");
      bus(1'b1, SSCR_CTRL_OFFS, 32'h20);
      rx(8'h11);
      rx(8'h22);
      rd(SSCR_CTRL_OFFS, 32'h20);
      bus(1'b1, SSCR_BUF_OFFS, 32'ha5);
      bus(1'b1, SSCR_BUF_OFFS, 32'h5a);
      rd(SSCR_CTRL_OFFS, 32'ha0);
      bus(1'b1, SSCR_CTRL_OFFS, 32'h04);
      rx(8'h33);
      rd(SSCR_CTRL_OFFS, 32'h04);
      $display("master and disabled done");
      print_verdict();
   end
endmodule
bind sscr_ctrl sscr_mon mon(.*);
`default_nettype wire
